// file: ocp_config_bank.sv
// Purpose: register bank for out_six/out_seven source selection and loop-zero analog settings
// Assumes: one byte access per cycle from the serial host port engine, inputs synchronous
// Notes:   all outputs are flops; derived outputs update together with the stored fields
`timescale 1ns/1ps
// Function
// - out_six selector, 3 bits, resets 000
// - out_seven selector, same codes, resets 101
// - reserved bits written zero, read back zero
// - pump current 3 bits, resets 100
// - series resistor 2 bits, rising codes
// - parallel capacitor 2 bits, rising codes
// - second pole bit, resets one
// - lock accuracy bit, resets one
// - override bit resets zero, one means manual
// - vco1 manual setting 5 bits read/write
// - vco2 manual setting 5 bits, resets zero
// - synth-only bit resets zero, crystal only
module ocp_config_bank #(
    parameter int unsigned ADDR_W = 16
) (
    // clock and reset
    input  wire logic                     i_clk_sys,
    input  wire logic                     i_rst,
    // byte register port
    input  wire logic [ADDR_W-1:0]        i_reg_addr,
    input  wire logic [7:0]               i_reg_wdata,
    input  wire logic                     i_reg_wr,
    input  wire logic                     i_reg_rd,
    output logic      [7:0]               o_reg_rdata,
    output logic                          o_reg_rvalid,
    // output multiplexer control
    output ocp_pkg::ocp_src_sel_t         o_src_sel,
    output logic                          o_out6_enable,
    output logic                          o_out7_enable,
    // loop-zero analog control
    output ocp_pkg::ocp_loop_zero_cfg_t        o_loop_zero_cfg,
    output ocp_pkg::ocp_manual_lock_t     o_loop_zero_manual,
    output logic                          o_loop_zero_crystal_only
);
    import ocp_pkg::*;

    ocp_src_sel_t     src;          // stored selectors
    ocp_src_sel_t     next_src;
    ocp_loop_zero_cfg_t    cfg;          // stored loop settings
    ocp_loop_zero_cfg_t    next_cfg;
    logic             out6_en;      // out_six forwarding allowed
    logic             next_out6_en;
    logic             out7_en;
    logic             next_out7_en;
    ocp_manual_lock_t man;          // gated manual lock values
    ocp_manual_lock_t next_man;
    logic             xtal_only;    // loop zero on crystal only
    logic             next_xtal_only;
    logic [7:0]       rdata;        // read return byte
    logic [7:0]       next_rdata;
    logic             rvalid;
    logic             next_rvalid;

    // write decode and derived control values
    always_comb begin
        next_src = src;
        next_cfg = cfg;
        if (i_reg_wr) begin
            unique case (i_reg_addr)
                OCP_ADDR_SRC_SEL: begin
                    next_src.out6_source_code = i_reg_wdata[OCP_SEL6_LSB +: 3];
                    next_src.out7_source_code = i_reg_wdata[OCP_SEL7_LSB +: 3];
                end
                OCP_ADDR_PUMP_FLT: begin
                    next_cfg.loop_zero_pump_current = i_reg_wdata[OCP_PUMP_LSB +: 3];
                    next_cfg.loop_zero_series_res   = i_reg_wdata[OCP_SERIES_LSB +: 2];
                    next_cfg.loop_zero_parallel_cap = i_reg_wdata[OCP_CAP_LSB +: 2];
                    next_cfg.loop_zero_second_pole  = i_reg_wdata[OCP_POLE_BIT];
                end
                OCP_ADDR_MODE_LCK: begin
                    next_cfg.loop_zero_synth_only    = i_reg_wdata[OCP_SYNTH_BIT];
                    next_cfg.loop_zero_lock_accuracy = i_reg_wdata[OCP_ACC_BIT];
                    next_cfg.loop_zero_lock_override = i_reg_wdata[OCP_OVR_BIT];
                end
                OCP_ADDR_VCO1_MAN: begin
                    next_cfg.loop_zero_vco_manual_pick   = i_reg_wdata[OCP_PICK_BIT];
                    next_cfg.loop_zero_vco1_lock_setting = i_reg_wdata[OCP_DBIT_LSB +: 5];
                end
                OCP_ADDR_VCO2_MAN: begin
                    next_cfg.loop_zero_vco2_lock_setting = i_reg_wdata[OCP_DBIT_LSB +: 5];
                end
                // unmapped addresses change nothing
                default: begin
                end
            endcase
        end
        next_out6_en = (next_src.out6_source_code != OCP_SRC_RESERVED);
        next_out7_en = (next_src.out7_source_code != OCP_SRC_RESERVED);
        // manual values reach the loop only in manual mode
        next_man.active   = next_cfg.loop_zero_lock_override;
        next_man.vco_pick = next_cfg.loop_zero_lock_override & next_cfg.loop_zero_vco_manual_pick;
        next_man.vco1     = next_cfg.loop_zero_lock_override ? next_cfg.loop_zero_vco1_lock_setting : 5'h00;
        next_man.vco2     = next_cfg.loop_zero_lock_override ? next_cfg.loop_zero_vco2_lock_setting : 5'h00;
        next_xtal_only = next_cfg.loop_zero_synth_only;
    end

    // config and derived control registers
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            src       <= OCP_SRC_RST;
            cfg       <= OCP_LOOP_ZERO_RST;
            out6_en   <= 1'b1;
            out7_en   <= 1'b1;
            man       <= '0;
            xtal_only <= 1'b0;
        end else begin
            src       <= next_src;
            cfg       <= next_cfg;
            out6_en   <= next_out6_en;
            out7_en   <= next_out7_en;
            man       <= next_man;
            xtal_only <= next_xtal_only;
        end
    end

    // read path, returns stored value before any same-cycle write
    always_comb begin
        next_rdata  = 8'h00;
        next_rvalid = i_reg_rd;
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                OCP_ADDR_SRC_SEL: begin
                    next_rdata[OCP_SEL6_LSB +: 3] = src.out6_source_code;
                    next_rdata[OCP_SEL7_LSB +: 3] = src.out7_source_code;
                end
                OCP_ADDR_PUMP_FLT: begin
                    next_rdata[OCP_PUMP_LSB +: 3]   = cfg.loop_zero_pump_current;
                    next_rdata[OCP_SERIES_LSB +: 2] = cfg.loop_zero_series_res;
                    next_rdata[OCP_CAP_LSB +: 2]    = cfg.loop_zero_parallel_cap;
                    next_rdata[OCP_POLE_BIT]        = cfg.loop_zero_second_pole;
                end
                OCP_ADDR_MODE_LCK: begin
                    next_rdata[OCP_SYNTH_BIT] = cfg.loop_zero_synth_only;
                    next_rdata[OCP_ACC_BIT]   = cfg.loop_zero_lock_accuracy;
                    next_rdata[OCP_OVR_BIT]   = cfg.loop_zero_lock_override;
                end
                OCP_ADDR_VCO1_MAN: begin
                    next_rdata[OCP_PICK_BIT]      = cfg.loop_zero_vco_manual_pick;
                    next_rdata[OCP_DBIT_LSB +: 5] = cfg.loop_zero_vco1_lock_setting;
                end
                OCP_ADDR_VCO2_MAN: begin
                    next_rdata[OCP_DBIT_LSB +: 5] = cfg.loop_zero_vco2_lock_setting;
                end
                // unmapped reads return zero
                default: begin
                end
            endcase
        end
    end

    // read registers
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            rdata  <= 8'h00;
            rvalid <= 1'b0;
        end else begin
            rdata  <= next_rdata;
            rvalid <= next_rvalid;
        end
    end

    // outputs straight from flops
    assign o_reg_rdata         = rdata;
    assign o_reg_rvalid        = rvalid;
    assign o_src_sel           = src;
    assign o_out6_enable       = out6_en;
    assign o_out7_enable       = out7_en;
    assign o_loop_zero_cfg          = cfg;
    assign o_loop_zero_manual       = man;
    assign o_loop_zero_crystal_only = xtal_only;

    // checks
    sequence s_wr(logic [15:0] a);
        i_reg_wr && (i_reg_addr == a);
    endsequence

    property p_out6_wr;
        @(posedge i_clk_sys) disable iff (i_rst)
        s_wr(OCP_ADDR_SRC_SEL) |=> o_src_sel.out6_source_code == $past(i_reg_wdata[2:0]);
    endproperty
    a_out6_wr: assert property (p_out6_wr) else $error("out6 code not stored");

    property p_out7_wr;
        @(posedge i_clk_sys) disable iff (i_rst)
        s_wr(OCP_ADDR_SRC_SEL) |=> o_src_sel.out7_source_code == $past(i_reg_wdata[6:4]);
    endproperty
    a_out7_wr: assert property (p_out7_wr) else $error("out7 code not stored");

    property p_rsvd_read;
        @(posedge i_clk_sys) disable iff (i_rst)
        i_reg_rd && (i_reg_addr == OCP_ADDR_MODE_LCK) |=> o_reg_rvalid && o_reg_rdata[7:4] == 4'h0;
    endproperty
    a_rsvd_read: assert property (p_rsvd_read) else $error("reserved bits not zero");

    property p_pump_wr;
        @(posedge i_clk_sys) disable iff (i_rst)
        s_wr(OCP_ADDR_PUMP_FLT) |=> o_loop_zero_cfg.loop_zero_pump_current == $past(i_reg_wdata[7:5])
            && o_loop_zero_cfg.loop_zero_series_res == $past(i_reg_wdata[4:3]);
    endproperty
    a_pump_wr: assert property (p_pump_wr) else $error("pump or resistor wrong");

    property p_cap_wr;
        @(posedge i_clk_sys) disable iff (i_rst)
        s_wr(OCP_ADDR_PUMP_FLT) |=> o_loop_zero_cfg.loop_zero_parallel_cap == $past(i_reg_wdata[2:1])
            && o_loop_zero_cfg.loop_zero_second_pole == $past(i_reg_wdata[0]);
    endproperty
    a_cap_wr: assert property (p_cap_wr) else $error("capacitor or pole wrong");

    property p_acc_wr;
        @(posedge i_clk_sys) disable iff (i_rst)
        s_wr(OCP_ADDR_MODE_LCK) |=> o_loop_zero_cfg.loop_zero_lock_accuracy == $past(i_reg_wdata[1]);
    endproperty
    a_acc_wr: assert property (p_acc_wr) else $error("lock accuracy wrong");

    property p_auto_zero;
        @(posedge i_clk_sys) disable iff (i_rst)
        !o_loop_zero_cfg.loop_zero_lock_override |-> !o_loop_zero_manual.active && o_loop_zero_manual.vco1 == 5'h00;
    endproperty
    a_auto_zero: assert property (p_auto_zero) else $error("manual values leak in auto");

    property p_vco1_man;
        @(posedge i_clk_sys) disable iff (i_rst)
        s_wr(OCP_ADDR_VCO1_MAN) ##1 o_loop_zero_cfg.loop_zero_lock_override
            |-> o_loop_zero_manual.vco1 == $past(i_reg_wdata[4:0]);
    endproperty
    a_vco1_man: assert property (p_vco1_man) else $error("vco1 manual wrong");

    property p_vco2_man;
        @(posedge i_clk_sys) disable iff (i_rst)
        o_loop_zero_cfg.loop_zero_lock_override |-> o_loop_zero_manual.vco2 == o_loop_zero_cfg.loop_zero_vco2_lock_setting;
    endproperty
    a_vco2_man: assert property (p_vco2_man) else $error("vco2 manual wrong");

    property p_synth;
        @(posedge i_clk_sys) disable iff (i_rst)
        s_wr(OCP_ADDR_MODE_LCK) |=> o_loop_zero_crystal_only == $past(i_reg_wdata[3]);
    endproperty
    a_synth: assert property (p_synth) else $error("crystal-only not following");

    property p_rsvd_src;
        @(posedge i_clk_sys) disable iff (i_rst)
        (o_src_sel.out6_source_code == OCP_SRC_RESERVED) |-> !o_out6_enable;
    endproperty
    a_rsvd_src: assert property (p_rsvd_src) else $error("reserved source forwarded");

endmodule // ocp_config_bank

// file: ocp_pkg.sv
// Purpose: shared constants and carriers for the output source and loop-zero config bank
// Assumes: byte-wide register port from the serial host port engine
// Notes:   reserved bits are not stored and read back as zero
package ocp_pkg;
    // register byte addresses
    localparam logic [15:0] OCP_ADDR_SRC_SEL  = 16'h00AA; // out_six / out_seven sources
    localparam logic [15:0] OCP_ADDR_PUMP_FLT = 16'h00AC; // pump and filter
    localparam logic [15:0] OCP_ADDR_MODE_LCK = 16'h00AD; // mode and lock control
    localparam logic [15:0] OCP_ADDR_VCO1_MAN = 16'h00AE; // vco1 manual lock
    localparam logic [15:0] OCP_ADDR_VCO2_MAN = 16'h00AF; // vco2 manual lock
    // field positions inside each byte
    localparam int unsigned OCP_SEL6_LSB   = 0;
    localparam int unsigned OCP_SEL7_LSB   = 4;
    localparam int unsigned OCP_PUMP_LSB   = 5;
    localparam int unsigned OCP_SERIES_LSB = 3;
    localparam int unsigned OCP_CAP_LSB    = 1;
    localparam int unsigned OCP_POLE_BIT   = 0;
    localparam int unsigned OCP_SYNTH_BIT  = 3;
    localparam int unsigned OCP_ACC_BIT    = 1;
    localparam int unsigned OCP_OVR_BIT    = 0;
    localparam int unsigned OCP_PICK_BIT   = 5;
    localparam int unsigned OCP_DBIT_LSB   = 0;
    // source codes for the output selectors
    localparam logic [2:0] OCP_SRC_LOOP_ZERO = 3'h0;
    localparam logic [2:0] OCP_SRC_LOOP_ONE  = 3'h1;
    localparam logic [2:0] OCP_SRC_OUT_TWO   = 3'h2;
    localparam logic [2:0] OCP_SRC_OUT_THREE = 3'h3;
    localparam logic [2:0] OCP_SRC_REF_ZERO  = 3'h4;
    localparam logic [2:0] OCP_SRC_REF_ONE   = 3'h5;
    localparam logic [2:0] OCP_SRC_RESERVED  = 3'h6;
    localparam logic [2:0] OCP_SRC_CRYSTAL   = 3'h7;
    // output source selectors
    typedef struct packed {
        logic [2:0] out7_source_code;
        logic [2:0] out6_source_code;
    } ocp_src_sel_t;
    // loop-zero analog settings
    typedef struct packed {
        logic [2:0] loop_zero_pump_current;
        logic [1:0] loop_zero_series_res;
        logic [1:0] loop_zero_parallel_cap;
        logic       loop_zero_second_pole;
        logic       loop_zero_synth_only;
        logic       loop_zero_lock_accuracy;
        logic       loop_zero_lock_override;
        logic       loop_zero_vco_manual_pick;
        logic [4:0] loop_zero_vco1_lock_setting;
        logic [4:0] loop_zero_vco2_lock_setting;
    } ocp_loop_zero_cfg_t;
    // manual lock values handed to the loop, zero while automatic
    typedef struct packed {
        logic       active;
        logic       vco_pick;
        logic [4:0] vco1;
        logic [4:0] vco2;
    } ocp_manual_lock_t;
    // reset values
    localparam ocp_src_sel_t OCP_SRC_RST = '{out7_source_code: 3'h5, out6_source_code: 3'h0};
    localparam ocp_loop_zero_cfg_t OCP_LOOP_ZERO_RST = '{
        loop_zero_pump_current: 3'h4, loop_zero_series_res: 2'h1, loop_zero_parallel_cap: 2'h1,
        loop_zero_second_pole: 1'h1, loop_zero_synth_only: 1'h0, loop_zero_lock_accuracy: 1'h1,
        loop_zero_lock_override: 1'h0, loop_zero_vco_manual_pick: 1'h1,
        loop_zero_vco1_lock_setting: 5'h0B, loop_zero_vco2_lock_setting: 5'h00};
endpackage

// file: test_outsel_and_loop_zero_loop_config.sv
// Purpose: self-checking bench for the output source and loop-zero config bank
// Assumes: byte register port, strobes driven on the falling edge of i_clk_sys
// Notes:   reserved bits are written as zero except where reserved handling is probed
`timescale 1ns/1ps
module test_outsel_and_loop_zero_loop_config;
    import ocp_pkg::*;
    // clock, reset and register port
    logic                i_clk_sys;
    logic                i_rst;
    logic [15:0]         i_reg_addr;
    logic [7:0]          i_reg_wdata;
    logic                i_reg_wr;
    logic                i_reg_rd;
    logic [7:0]          o_reg_rdata;
    logic                o_reg_rvalid;
    // control outputs
    ocp_src_sel_t        o_src_sel;
    logic                o_out6_enable;
    logic                o_out7_enable;
    ocp_loop_zero_cfg_t       o_loop_zero_cfg;
    ocp_manual_lock_t    o_loop_zero_manual;
    logic                o_loop_zero_crystal_only;
    int                  err_total;
    int                  samples_checked;

    ocp_config_bank DUT (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .o_src_sel(o_src_sel),
        .o_out6_enable(o_out6_enable), .o_out7_enable(o_out7_enable),
        .o_loop_zero_cfg(o_loop_zero_cfg), .o_loop_zero_manual(o_loop_zero_manual),
        .o_loop_zero_crystal_only(o_loop_zero_crystal_only));

    // 100 ns clock
    initial begin
        i_clk_sys = 1'b0;
        forever #50 i_clk_sys = ~i_clk_sys;
    end

    // compare one value and count it
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // one write strobe, held across one rising edge
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(negedge i_clk_sys);
        i_reg_addr = a;
        i_reg_wdata = d;
        i_reg_wr = 1'b1;
        @(negedge i_clk_sys);
        i_reg_wr = 1'b0;
    endtask

    // one read strobe, answer sampled just after it drops at the next falling edge
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        @(negedge i_clk_sys);
        i_reg_addr = a;
        i_reg_rd = 1'b1;
        @(negedge i_clk_sys);
        i_reg_rd = 1'b0;
        chk(32'(o_reg_rvalid), 32'h0000_0001, "read valid");
        chk(32'(o_reg_rdata), 32'(exp), "read byte");
    endtask

    // defaults after reset at the ports and through the register port
    task automatic t_reset();
        chk(32'(o_src_sel), 32'({3'h5, 3'h0}), "reset selectors");
        chk(32'({o_out6_enable, o_out7_enable}), 32'h0000_0003, "reset enables");
        chk(32'(o_loop_zero_cfg), 32'({3'h4, 2'h1, 2'h1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 5'h0B,
            5'h00}), "reset loop cfg");
        chk(32'(o_loop_zero_manual), 32'h0000_0000, "reset manual");
        chk(32'(o_loop_zero_crystal_only), 32'h0000_0000, "reset crystal");
        rd_chk(OCP_ADDR_SRC_SEL, 8'h50);
        rd_chk(OCP_ADDR_PUMP_FLT, 8'h8B);
        rd_chk(OCP_ADDR_MODE_LCK, 8'h02);
        rd_chk(OCP_ADDR_VCO1_MAN, 8'h2B);
        rd_chk(OCP_ADDR_VCO2_MAN, 8'h00);
    endtask

    // every source code on both selectors, reserved code stops the output
    task automatic t_sel_codes();
        logic [2:0] c;
        logic [2:0] k;
        for (int n = 0; n < 8; n++) begin
            c = 3'(n);
            k = ~c;
            wr_reg(OCP_ADDR_SRC_SEL, {1'b0, k, 1'b0, c});
            chk(32'(o_src_sel), 32'({k, c}), "selector codes");
            chk(32'(o_out6_enable), 32'(c != OCP_SRC_RESERVED), "out six enable");
            chk(32'(o_out7_enable), 32'(k != OCP_SRC_RESERVED), "out seven enable");
            rd_chk(OCP_ADDR_SRC_SEL, {1'b0, k, 1'b0, c});
        end
    endtask

    // pump current, series resistor, capacitor and pole over all codes
    task automatic t_pump_filter();
        logic [2:0] c;
        for (int n = 0; n < 8; n++) begin
            c = 3'(n);
            wr_reg(OCP_ADDR_PUMP_FLT, {c, c[1:0], c[2:1], c[0]});
            chk(32'(o_loop_zero_cfg.loop_zero_pump_current), 32'(c), "pump current");
            chk(32'(o_loop_zero_cfg.loop_zero_series_res), 32'(c[1:0]), "series res");
            chk(32'(o_loop_zero_cfg.loop_zero_parallel_cap), 32'(c[2:1]), "parallel cap");
            chk(32'(o_loop_zero_cfg.loop_zero_second_pole), 32'(c[0]), "second pole");
            rd_chk(OCP_ADDR_PUMP_FLT, {c, c[1:0], c[2:1], c[0]});
        end
    endtask

    // manual lock values pass only while override is set
    task automatic t_lock_manual();
        wr_reg(OCP_ADDR_VCO1_MAN, 8'h35);
        wr_reg(OCP_ADDR_VCO2_MAN, 8'h1A);
        wr_reg(OCP_ADDR_MODE_LCK, 8'h00);
        chk(32'(o_loop_zero_manual), 32'h0000_0000, "automatic hides manual");
        chk(32'(o_loop_zero_cfg.loop_zero_lock_accuracy), 32'h0000_0000, "fine accuracy");
        wr_reg(OCP_ADDR_MODE_LCK, 8'h01);
        chk(32'(o_loop_zero_manual), 32'({2'b11, 5'h15, 5'h1A}), "manual values");
        rd_chk(OCP_ADDR_VCO1_MAN, 8'h35);
        rd_chk(OCP_ADDR_VCO2_MAN, 8'h1A);
        wr_reg(OCP_ADDR_VCO1_MAN, 8'h0E);
        chk(32'(o_loop_zero_manual), 32'({2'b10, 5'h0E, 5'h1A}), "manual rewrite");
        rd_chk(OCP_ADDR_VCO1_MAN, 8'h0E);
        // loop state forced to free-run by host
        wr_reg(OCP_ADDR_MODE_LCK, 8'h08);
        chk(32'(o_loop_zero_crystal_only), 32'h0000_0001, "crystal only");
        chk(32'(o_loop_zero_manual), 32'h0000_0000, "override off again");
        rd_chk(OCP_ADDR_MODE_LCK, 8'h08);
    endtask

    // reserved bits, unmapped places and a read beside a write
    task automatic t_reserved();
        wr_reg(OCP_ADDR_MODE_LCK, 8'hFF);
        rd_chk(OCP_ADDR_MODE_LCK, 8'h0B);
        wr_reg(OCP_ADDR_VCO2_MAN, 8'hFF);
        rd_chk(OCP_ADDR_VCO2_MAN, 8'h1F);
        wr_reg(16'h00AB, 8'hFF);
        wr_reg(16'h00B0, 8'hFF);
        rd_chk(16'h00AB, 8'h00);
        rd_chk(16'h00B0, 8'h00);
        @(negedge i_clk_sys);
        chk(32'(o_reg_rvalid), 32'h0000_0000, "valid one cycle");
        chk(32'(o_reg_rdata), 32'h0000_0000, "data one cycle");
        rd_chk(OCP_ADDR_PUMP_FLT, 8'hFF);
        // let the read strobe settle low before raising it again
        @(negedge i_clk_sys);
        i_reg_addr = OCP_ADDR_PUMP_FLT;
        i_reg_wdata = 8'h55;
        i_reg_wr = 1'b1;
        i_reg_rd = 1'b1;
        @(negedge i_clk_sys);
        i_reg_wr = 1'b0;
        i_reg_rd = 1'b0;
        chk(32'(o_reg_rdata), 32'h0000_00FF, "read before write");
        chk(32'(o_loop_zero_cfg.loop_zero_pump_current), 32'h0000_0002, "pump after write");
        chk(32'(o_loop_zero_cfg.loop_zero_series_res), 32'h0000_0002, "series after write");
    endtask

    // verdict and end of run
    task automatic print_verdict();
        if (err_total == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        err_total = 0;
        samples_checked = 0;
        i_rst = 1'b1;
        i_reg_addr = 16'h0000;
        i_reg_wdata = 8'h00;
        i_reg_wr = 1'b0;
        i_reg_rd = 1'b0;
        repeat (3) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        i_rst = 1'b0;
        t_reset();
        t_sel_codes();
        t_pump_filter();
        t_lock_manual();
        t_reserved();
        print_verdict();
    end

    // watchdog well beyond the roughly 115 cycles the tests need
    initial begin
        #200000;
        err_total++;
        print_verdict();
    end
endmodule // test_outsel_and_loop_zero_loop_config
